// *** sim/dtcg_pin_model.sv ***
// Purpose: far-side model of the gate and count pins of both timers
// Assumes: period is one peripheral cycle counted in clocks
// Notes: pins idle high, as a pulled-up input would
`timescale 1ns/100ps
`default_nettype none

module dtcg_pin_model #(
    parameter int PERIOD = 2
) (
    input wire logic ref_clk,
    output logic [1:0] gate_pin,
    output logic [1:0] count_pin
);
    initial begin
        gate_pin = 2'h3;
        count_pin = 2'h3;
    end

    task automatic set_gate(input int i, input logic v);
        @(posedge ref_clk);
        #2 gate_pin[i] = v;
    endtask

    // w stretches each level; one cycle alone could be missed by sampling
    task automatic pulse(input int i, input int n, input int w);
        repeat (n) begin
            repeat (2 * w * PERIOD) @(posedge ref_clk);
            #2 count_pin[i] = 1'b0;
            repeat (2 * w * PERIOD) @(posedge ref_clk);
            #2 count_pin[i] = 1'b1;
        end
    endtask
endmodule

`default_nettype wire

// *** sim/dtcg_top_monitor.sv ***
// Purpose: port-level checks of the dual gated timer/counter
// Assumes: software-only bits are shadowed from bus writes
// Notes: flag checks other than chk_ovf_zero_bit skip cycles with a bus write, which may override
`timescale 1ns/100ps
`default_nettype none

module dtcg_top_monitor #(
    parameter int PERIPH_DIV = 6
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic gate_pin_zero,
    input wire logic gate_pin_one,
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic ack_overflow_zero,
    input wire logic ack_overflow_one,
    input wire logic ack_ext_irq_zero,
    input wire logic ack_ext_irq_one,
    input wire logic overflow_flag_zero,
    input wire logic overflow_flag_one,
    input wire logic ext_irq_flag_zero,
    input wire logic ext_irq_flag_one,
    input wire logic baud_tick_one
);
    logic [7:0] mode_reg, mode_next;
    logic [1:0] soft_reg, soft_next;
    logic wr_ctrl, wr_mode, quiet, hold_one;

    assign wr_ctrl = clk_en && sfr_wr && sfr_addr == 8'h88;
    assign wr_mode = clk_en && sfr_wr && sfr_addr == 8'h89;
    assign quiet = clk_en && !sfr_wr;
    assign hold_one = mode_reg[5:4] == 2'h3 && mode_reg[1:0] != 2'h3;

    // run0 and type0 are never touched by hardware, so a shadow is exact
    always_comb begin
        mode_next = wr_mode ? sfr_wdata : mode_reg;
        soft_next = wr_ctrl ? {sfr_wdata[4], sfr_wdata[0]} : soft_reg;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= 8'h00;
            soft_reg <= 2'h0;
        end else begin
            mode_reg <= mode_next;
            soft_reg <= soft_next;
        end
    end

    default clocking mon_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_mode_readback: assert property (
        clk_en && sfr_rd && sfr_addr == 8'h89
        |=> sfr_rdata == $past(mode_reg)) else $error("mode read back wrong");
    chk_ovf_zero_bit: assert property (
        wr_ctrl && sfr_wdata[5] && !ack_overflow_zero |=> overflow_flag_zero)
        else $error("ctrl bit 5 did not reach overflow flag zero");
    chk_run_stops: assert property (
        (quiet && !soft_reg[1])[*2] |=> !$rose(overflow_flag_zero))
        else $error("timer zero overflowed while stopped");
    chk_gate_blocks: assert property (
        (quiet && mode_reg[3] && !gate_pin_zero)[*5]
        |=> !$rose(overflow_flag_zero)) else $error("gated timer counted");
    chk_halt_one: assert property (
        (quiet && hold_one)[*3] |-> !baud_tick_one && !$rose(overflow_flag_one))
        else $error("halted timer one overflowed");
    chk_level_irq: assert property (
        (quiet && !soft_reg[0] && !gate_pin_zero)[*5] |-> ext_irq_flag_zero)
        else $error("level irq flag zero not set by low pin");
    chk_ack_clears: assert property (
        quiet && ack_overflow_zero && !soft_reg[1] && !$past(soft_reg[1])
        |=> !overflow_flag_zero) else $error("ack left overflow flag zero");
    chk_baud_pulse: assert property (
        baud_tick_one && clk_en |=> !baud_tick_one)
        else $error("baud tick longer than one cycle");
endmodule

bind dtcg_top dtcg_top_monitor #(.PERIPH_DIV(PERIPH_DIV)) chk_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .gate_pin_zero(gate_pin_zero), .gate_pin_one(gate_pin_one),
    .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
    .ack_overflow_zero(ack_overflow_zero),
    .ack_overflow_one(ack_overflow_one),
    .ack_ext_irq_zero(ack_ext_irq_zero), .ack_ext_irq_one(ack_ext_irq_one),
    .overflow_flag_zero(overflow_flag_zero),
    .overflow_flag_one(overflow_flag_one),
    .ext_irq_flag_zero(ext_irq_flag_zero),
    .ext_irq_flag_one(ext_irq_flag_one), .baud_tick_one(baud_tick_one)
);

`default_nettype wire

// *** sim/test_dual_timer_counter_gated.sv ***
// Purpose: self-checking bench of the dual gated timer/counter
// Assumes: short peripheral cycle so every count finishes quickly
// Notes: flg holds ovf0, ovf1, ext0, ext1, baud from bit 0 up
`timescale 1ns/100ps
`default_nettype none

module test_dual_timer_counter_gated;
    localparam int P = 2;
    logic ref_clk, rst_n, clk_en, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
    logic [1:0] gate_pin, count_pin, ack_ovf, ack_ext;
    logic [4:0] flg;
    int errors, checks;

    dtcg_top #(.PERIPH_DIV(P)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .gate_pin_zero(gate_pin[0]), .gate_pin_one(gate_pin[1]),
        .count_pin_zero(count_pin[0]), .count_pin_one(count_pin[1]),
        .ack_overflow_zero(ack_ovf[0]), .ack_overflow_one(ack_ovf[1]),
        .ack_ext_irq_zero(ack_ext[0]), .ack_ext_irq_one(ack_ext[1]),
        .overflow_flag_zero(flg[0]), .overflow_flag_one(flg[1]),
        .ext_irq_flag_zero(flg[2]), .ext_irq_flag_one(flg[3]),
        .baud_tick_one(flg[4])
    );
    dtcg_pin_model #(.PERIOD(P)) pins (
        .ref_clk(ref_clk), .gate_pin(gate_pin), .count_pin(count_pin)
    );

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmpf(input logic got, input logic exp);
        cmp({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #2 sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge ref_clk);
        #2 sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        #2 sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge ref_clk);
        #2 sfr_rd = 1'b0;
        v = sfr_rdata;
    endtask
    task automatic ack(input logic [3:0] m);
        @(posedge ref_clk);
        #2 {ack_ext, ack_ovf} = m;
        @(posedge ref_clk);
        #2 {ack_ext, ack_ovf} = 4'h0;
    endtask
    task automatic wait_lv(input int i, input logic lv);
        for (int k = 0; k < 400 && flg[i] !== lv; k++) begin
            @(posedge ref_clk);
            #2;
        end
    endtask
    task automatic conclude();
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        for (int k = 0; k < 7; k++) begin
            rd((k == 6) ? 8'h80 : 8'h88 + k[7:0]);
            cmp(v, 8'h00);
        end
    endtask
    task automatic t_mode1();
        wr(8'h89, 8'h01);
        wr(8'h8a, 8'hfe);
        wr(8'h8c, 8'hff);
        wr(8'h88, 8'h10);
        wait_lv(0, 1'b1);
        cmpf(flg[0], 1'b1);
        wr(8'h88, 8'h20);
        rd(8'h8c);
        cmp(v, 8'h00);
        rd(8'h89);
        cmp(v, 8'h01);
        ack(4'h1);
        cmpf(flg[0], 1'b0);
    endtask
    task automatic t_reload();
        wr(8'h89, 8'h20);
        wr(8'h8b, 8'hfe);
        wr(8'h8d, 8'h10);
        wr(8'h88, 8'h40);
        wait_lv(4, 1'b1);
        cmpf(flg[4], 1'b1);
        cmpf(flg[1], 1'b1);
        wr(8'h88, 8'h00);
        rd(8'h8d);
        cmp(v, 8'h10);
        rd(8'h8b);
        cmp(v & 8'hfe, 8'h10);
    endtask
    task automatic t_presc();
        wr(8'h8a, 8'hff);
        wr(8'h8c, 8'h05);
        wr(8'h89, 8'h04);
        wr(8'h88, 8'h10);
        pins.pulse(0, 1, 1);
        wr(8'h88, 8'h00);
        rd(8'h8a);
        cmp(v, 8'he0);
        rd(8'h8c);
        cmp(v, 8'h06);
    endtask
    task automatic t_gate();
        wr(8'h8a, 8'h00);
        wr(8'h89, 8'h0d);
        pins.set_gate(0, 1'b0);
        wr(8'h88, 8'h10);
        pins.pulse(0, 2, 1);
        pins.set_gate(0, 1'b1);
        pins.pulse(0, 3, 1);
        wr(8'h88, 8'h00);
        rd(8'h8a);
        cmp(v, 8'h03);
    endtask
    task automatic t_hold();
        wr(8'h8b, 8'h00);
        wr(8'h89, 8'h70);
        wr(8'h88, 8'h40);
        pins.pulse(1, 2, 1);
        rd(8'h8b);
        cmp(v, 8'h00);
        wr(8'h89, 8'hd0);
        pins.pulse(1, 2, 2);
        wr(8'h88, 8'h00);
        rd(8'h8b);
        cmp(v, 8'h02);
    endtask
    task automatic t_split();
        wr(8'h8a, 8'h00);
        wr(8'h8c, 8'hfe);
        wr(8'h89, 8'h03);
        wr(8'h88, 8'h40);
        wait_lv(1, 1'b1);
        cmpf(flg[1], 1'b1);
        cmpf(flg[0], 1'b0);
        ack(4'h2);
        cmpf(flg[1], 1'b0);
        wr(8'h88, 8'h00);
        rd(8'h8a);
        cmp(v, 8'h00);
    endtask
    task automatic t_ext();
        for (int i = 0; i < 2; i++) begin
            wr(8'h88, (i == 1) ? 8'h04 : 8'h01);
            pins.set_gate(i, 1'b0);
            wait_lv(2 + i, 1'b1);
            cmpf(flg[2 + i], 1'b1);
            ack((i == 1) ? 4'h8 : 4'h4);
            cmpf(flg[2 + i], 1'b0);
            wr(8'h88, 8'h00);
            wait_lv(2 + i, 1'b1);
            cmpf(flg[2 + i], 1'b1);
            pins.set_gate(i, 1'b1);
            wait_lv(2 + i, 1'b0);
            cmpf(flg[2 + i], 1'b0);
        end
    endtask

    // a write while frozen must be lost; a second reset clears the counts
    task automatic t_freeze();
        wr(8'h8a, 8'h5a);
        @(posedge ref_clk);
        #2 clk_en = 1'b0;
        wr(8'h8a, 8'ha5);
        @(posedge ref_clk);
        #2 clk_en = 1'b1;
        rd(8'h8a);
        cmp(v, 8'h5a);
        @(posedge ref_clk);
        #2 rst_n = 1'b0;
        @(posedge ref_clk);
        #2 rst_n = 1'b1;
        rd(8'h8a);
        cmp(v, 8'h00);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        conclude();
    end
    initial begin
        {rst_n, sfr_wr, sfr_rd, ack_ovf, ack_ext} = 7'h00;
        clk_en = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        repeat (12) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        t_reset();
        t_mode1();
        t_reload();
        t_presc();
        t_gate();
        t_hold();
        t_split();
        t_ext();
        t_freeze();
        conclude();
    end
endmodule

`default_nettype wire

// *** src/dtcg_defs.svh ***
// Purpose: constants of the dual gated timer/counter block
// Assumes: register addresses are those of the special-function bus
// Notes: positions are bit indices inside the two 8-bit control registers
`ifndef DTCG_DEFS_SVH
`define DTCG_DEFS_SVH

`define DTCG_ADDR_CTRL_FLAGS 8'h88
`define DTCG_ADDR_MODE_SEL 8'h89
`define DTCG_ADDR_COUNT_LOW_ZERO 8'h8a
`define DTCG_ADDR_COUNT_LOW_ONE 8'h8b
`define DTCG_ADDR_COUNT_HIGH_ZERO 8'h8c
`define DTCG_ADDR_COUNT_HIGH_ONE 8'h8d

`define DTCG_CTRL_RESET 8'h00
`define DTCG_MODE_RESET 8'h00
`define DTCG_COUNT_RESET 8'h00
`define DTCG_UNMAPPED_READ 8'h00

// timer_mode_select fields
`define DTCG_MODE_GATE_ONE 7
`define DTCG_MODE_SEL_ONE 6
`define DTCG_MODE_HI_ONE 5
`define DTCG_MODE_LO_ONE 4
`define DTCG_MODE_GATE_ZERO 3
`define DTCG_MODE_SEL_ZERO 2
`define DTCG_MODE_HI_ZERO 1
`define DTCG_MODE_LO_ZERO 0

// timer_control_flags fields
`define DTCG_CTRL_OVF_ONE 7
`define DTCG_CTRL_RUN_ONE 6
`define DTCG_CTRL_OVF_ZERO 5
`define DTCG_CTRL_RUN_ZERO 4
`define DTCG_CTRL_EXT_FLAG_ONE 3
`define DTCG_CTRL_EXT_TYPE_ONE 2
`define DTCG_CTRL_EXT_FLAG_ZERO 1
`define DTCG_CTRL_EXT_TYPE_ZERO 0

// peripheral cycle length in clocks and prescaler wrap value
`define DTCG_PERIPH_DIV 6
`define DTCG_PRESC_MAX 5'h1f
`define DTCG_BYTE_MAX 8'hff

`endif

// *** src/dtcg_pin_sampler.sv ***
// Purpose: per-channel pin conditioning for gate and count pins
// Assumes: tick marks the one sampling clock of each peripheral cycle
// Notes: gate path is a two-stage synchroniser plus an edge stage
`timescale 1ns/100ps
`default_nettype none

module dtcg_pin_sampler (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic tick,
    input wire logic gate_pin,
    input wire logic count_pin,
    output logic gate_sync,
    output logic gate_fall,
    output logic count_fall
);

    logic gate_meta_reg, gate_meta_next;
    logic gate_sync_reg, gate_sync_next;
    logic gate_prev_reg, gate_prev_next;
    logic count_samp_reg, count_samp_next;
    logic count_fall_reg, count_fall_next;

    always_comb begin
        gate_meta_next = gate_pin;
        gate_sync_next = gate_meta_reg;
        gate_prev_next = gate_sync_reg;
        count_samp_next = count_samp_reg;
        count_fall_next = 1'b0;
        if (tick) begin
            // one sample per peripheral cycle: high then low counts once
            count_samp_next = count_pin;
            count_fall_next = count_samp_reg & ~count_pin;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_meta_reg <= 1'b1;
            gate_sync_reg <= 1'b1;
            gate_prev_reg <= 1'b1;
            count_samp_reg <= 1'b0;
            count_fall_reg <= 1'b0;
        end else if (clk_en) begin
            gate_meta_reg <= gate_meta_next;
            gate_sync_reg <= gate_sync_next;
            gate_prev_reg <= gate_prev_next;
            count_samp_reg <= count_samp_next;
            count_fall_reg <= count_fall_next;
        end
    end

    assign gate_sync = gate_sync_reg;
    assign gate_fall = gate_prev_reg & ~gate_sync_reg;
    assign count_fall = count_fall_reg;

endmodule

`default_nettype wire

// *** src/dtcg_pkg.sv ***
// Purpose: types shared by the dual gated timer/counter block
// Assumes: nothing beyond the defs header
// Notes: mode codes match the two-bit mode field of each timer
package dtcg_pkg;

    typedef enum logic [1:0] {
        DTCG_MODE_PRESCALED = 2'b00,
        DTCG_MODE_CASCADE = 2'b01,
        DTCG_MODE_RELOAD = 2'b10,
        DTCG_MODE_SPLIT = 2'b11
    } dtcg_mode_type;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic ovf;
    } dtcg_step_type;

endpackage

// *** src/dtcg_top.sv ***
// Purpose: two gated timer/counters behind special-function registers
// Assumes: single clock, pins synchronous, ack pulses from the vectoring
// Notes: register reads answer one clock after the read strobe
//
// What this block does
// - gate clear, run bit set lets selected source count; run clear stops.
// - gate set and run set: count only while gate pin is high.
// - select 0 counts peripheral cycles; select 1 counts count-pin falls.
// - timer zero uses mode bits 3..0; timer one mode bits 7..4.
// - mode field 00 prescaled, 01 sixteen bit, 10 reload, 11 mode three.
// - rollover of all ones to zero sets the timer overflow flag.
// - overflow flag clears when the processor vectors to its routine.
// - mode 0: five-bit prescaler in low register carries into high.
// - mode 1: high and low form one sixteen-bit counter.
// - mode 2: low counts, overflow reloads low from unchanged high.
// - zero in mode 3: low is an 8-bit timer with own controls.
// - zero in mode 3: high counts cycles, run one, sets flag one.
// - timer one in mode 3 halts and holds its count.
// - timer one matches zero in modes 0-2; overflow feeds baud clock.
// - external flags set on pin interrupt; edge type clears on service.
// - type bit 1 selects falling edge, 0 selects active-low level.
// - timer operation advances once per six-clock peripheral cycle.
// - counter mode samples once per cycle, counts a high-then-low pair.
// - run bit never clears counts; counts readable and writable anytime.
`timescale 1ns/100ps
`default_nettype none
`include "dtcg_defs.svh"

module dtcg_top
    import dtcg_pkg::*;
#(
    parameter int PERIPH_DIV = `DTCG_PERIPH_DIV
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic gate_pin_zero,
    input wire logic gate_pin_one,
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic ack_overflow_zero,
    input wire logic ack_overflow_one,
    input wire logic ack_ext_irq_zero,
    input wire logic ack_ext_irq_one,
    output logic overflow_flag_zero,
    output logic overflow_flag_one,
    output logic ext_irq_flag_zero,
    output logic ext_irq_flag_one,
    output logic baud_tick_one
);

    localparam int DIV_W = (PERIPH_DIV > 1) ? $clog2(PERIPH_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PERIPH_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

    generate
        if (PERIPH_DIV < 2 || PERIPH_DIV > 255) begin : g_bad_div
            $error("PERIPH_DIV must lie between 2 and 255");
        end
    endgenerate

    logic [DIV_W-1:0] div_reg, div_next;
    logic [7:0] mode_reg, mode_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] count_low_zero_reg, count_low_zero_next;
    logic [7:0] count_high_zero_reg, count_high_zero_next;
    logic [7:0] count_low_one_reg, count_low_one_next;
    logic [7:0] count_high_one_reg, count_high_one_next;
    logic [7:0] rdata_reg, rdata_next;
    logic baud_reg, baud_next;

    logic tick;
    logic [1:0] gate_sync;
    logic [1:0] gate_fall;
    logic [1:0] count_fall;
    logic [1:0] gate_pins;
    logic [1:0] count_pins;

    assign gate_pins = {gate_pin_one, gate_pin_zero};
    assign count_pins = {count_pin_one, count_pin_zero};

    // one clock in PERIPH_DIV is a peripheral cycle
    always_comb begin
        div_next = (div_reg == DIV_LAST) ? '0 : div_reg + DIV_ONE;
    end

    assign tick = (div_reg == DIV_LAST);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else if (clk_en) begin
            div_reg <= div_next;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_pins
            dtcg_pin_sampler u_sampler (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .tick(tick),
                .gate_pin(gate_pins[ch]),
                .count_pin(count_pins[ch]),
                .gate_sync(gate_sync[ch]),
                .gate_fall(gate_fall[ch]),
                .count_fall(count_fall[ch])
            );
        end
    endgenerate

    // advance one timer by one count in modes 0, 1 and 2;
    // in mode 3 only the low byte moves here
    function automatic dtcg_step_type count_step(
        input dtcg_mode_type mode,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        dtcg_step_type r;
        r.lo = lo;
        r.hi = hi;
        r.ovf = 1'b0;
        case (mode)
            DTCG_MODE_PRESCALED: begin
                // top three low bits are left alone
                r.lo = {lo[7:5], lo[4:0] + 5'h01};
                if (lo[4:0] == `DTCG_PRESC_MAX) begin
                    r.hi = hi + 8'h01;
                    r.ovf = (hi == `DTCG_BYTE_MAX);
                end
            end
            DTCG_MODE_CASCADE: begin
                r.lo = lo + 8'h01;
                if (lo == `DTCG_BYTE_MAX) begin
                    r.hi = hi + 8'h01;
                    r.ovf = (hi == `DTCG_BYTE_MAX);
                end
            end
            DTCG_MODE_RELOAD: begin
                if (lo == `DTCG_BYTE_MAX) begin
                    r.lo = hi;
                    r.ovf = 1'b1;
                end else begin
                    r.lo = lo + 8'h01;
                end
            end
            DTCG_MODE_SPLIT: begin
                r.lo = lo + 8'h01;
                r.ovf = (lo == `DTCG_BYTE_MAX);
            end
            default: begin
                r.lo = lo;
            end
        endcase
        return r;
    endfunction

    dtcg_mode_type mode_zero;
    dtcg_mode_type mode_one;
    logic run_zero, run_one;
    logic gate_en_zero, gate_en_one;
    logic sel_zero, sel_one;
    logic zero_split;
    logic inc_zero, inc_one, inc_high_zero;
    logic run_one_eff;
    dtcg_step_type step_zero, step_one;
    logic high_zero_ovf;
    logic ovf_one_raw;
    logic wr_ctrl;

    always_comb begin
        mode_zero = dtcg_mode_type'(mode_reg[`DTCG_MODE_HI_ZERO:
                                             `DTCG_MODE_LO_ZERO]);
        mode_one = dtcg_mode_type'(mode_reg[`DTCG_MODE_HI_ONE:
                                            `DTCG_MODE_LO_ONE]);
        gate_en_zero = mode_reg[`DTCG_MODE_GATE_ZERO];
        gate_en_one = mode_reg[`DTCG_MODE_GATE_ONE];
        sel_zero = mode_reg[`DTCG_MODE_SEL_ZERO];
        sel_one = mode_reg[`DTCG_MODE_SEL_ONE];
        run_zero = ctrl_reg[`DTCG_CTRL_RUN_ZERO];
        run_one = ctrl_reg[`DTCG_CTRL_RUN_ONE];
        zero_split = (mode_zero == DTCG_MODE_SPLIT);

        // timer zero low part: own run, gate and source in every mode
        inc_zero = run_zero & (~gate_en_zero | gate_sync[0])
                   & (sel_zero ? count_fall[0] : tick);

        // while zero is split, its high byte owns run one and flag one,
        // so timer one free-runs and only feeds the baud clock
        run_one_eff = zero_split ? 1'b1 : run_one;
        inc_one = (mode_one != DTCG_MODE_SPLIT)
                  & run_one_eff & (~gate_en_one | gate_sync[1])
                  & (sel_one ? count_fall[1] : tick);

        inc_high_zero = zero_split & run_one & tick;

        step_zero = count_step(mode_zero, count_low_zero_reg,
                               count_high_zero_reg);
        step_one = count_step(mode_one, count_low_one_reg,
                              count_high_one_reg);
        high_zero_ovf = inc_high_zero &
                        (count_high_zero_reg == `DTCG_BYTE_MAX);
        ovf_one_raw = inc_one & step_one.ovf;
        wr_ctrl = sfr_wr & (sfr_addr == `DTCG_ADDR_CTRL_FLAGS);
    end

    always_comb begin
        mode_next = mode_reg;
        ctrl_next = ctrl_reg;
        count_low_zero_next = count_low_zero_reg;
        count_high_zero_next = count_high_zero_reg;
        count_low_one_next = count_low_one_reg;
        count_high_one_next = count_high_one_reg;
        rdata_next = rdata_reg;
        baud_next = ovf_one_raw;

        // counting; run changes never touch the counts
        if (inc_zero) begin
            count_low_zero_next = step_zero.lo;
            if (!zero_split) begin
                count_high_zero_next = step_zero.hi;
            end
        end
        if (inc_high_zero) begin
            count_high_zero_next = count_high_zero_reg + 8'h01;
        end
        if (inc_one) begin
            count_low_one_next = step_one.lo;
            count_high_one_next = step_one.hi;
        end

        // a software write to a count byte wins over the count that cycle
        if (sfr_wr) begin
            case (sfr_addr)
                `DTCG_ADDR_MODE_SEL: mode_next = sfr_wdata;
                `DTCG_ADDR_CTRL_FLAGS: ctrl_next = sfr_wdata;
                `DTCG_ADDR_COUNT_LOW_ZERO:
                    count_low_zero_next = sfr_wdata;
                `DTCG_ADDR_COUNT_HIGH_ZERO:
                    count_high_zero_next = sfr_wdata;
                `DTCG_ADDR_COUNT_LOW_ONE:
                    count_low_one_next = sfr_wdata;
                `DTCG_ADDR_COUNT_HIGH_ONE:
                    count_high_one_next = sfr_wdata;
                default: ctrl_next = ctrl_reg;
            endcase
        end

        // service clears come first so a same-cycle event still lands
        if (ack_overflow_zero) begin
            ctrl_next[`DTCG_CTRL_OVF_ZERO] = 1'b0;
        end
        if (ack_overflow_one) begin
            ctrl_next[`DTCG_CTRL_OVF_ONE] = 1'b0;
        end
        if (ack_ext_irq_zero && ctrl_reg[`DTCG_CTRL_EXT_TYPE_ZERO]) begin
            ctrl_next[`DTCG_CTRL_EXT_FLAG_ZERO] = 1'b0;
        end
        if (ack_ext_irq_one && ctrl_reg[`DTCG_CTRL_EXT_TYPE_ONE]) begin
            ctrl_next[`DTCG_CTRL_EXT_FLAG_ONE] = 1'b0;
        end

        // hardware sets
        if (inc_zero && step_zero.ovf) begin
            ctrl_next[`DTCG_CTRL_OVF_ZERO] = 1'b1;
        end
        if (high_zero_ovf || (ovf_one_raw && !zero_split)) begin
            ctrl_next[`DTCG_CTRL_OVF_ONE] = 1'b1;
        end

        // level type tracks the pin; edge type latches a falling edge
        if (ctrl_reg[`DTCG_CTRL_EXT_TYPE_ZERO]) begin
            if (gate_fall[0]) begin
                ctrl_next[`DTCG_CTRL_EXT_FLAG_ZERO] = 1'b1;
            end
        end else if (!wr_ctrl) begin
            ctrl_next[`DTCG_CTRL_EXT_FLAG_ZERO] = ~gate_sync[0];
        end else if (!gate_sync[0]) begin
            ctrl_next[`DTCG_CTRL_EXT_FLAG_ZERO] = 1'b1;
        end
        if (ctrl_reg[`DTCG_CTRL_EXT_TYPE_ONE]) begin
            if (gate_fall[1]) begin
                ctrl_next[`DTCG_CTRL_EXT_FLAG_ONE] = 1'b1;
            end
        end else if (!wr_ctrl) begin
            ctrl_next[`DTCG_CTRL_EXT_FLAG_ONE] = ~gate_sync[1];
        end else if (!gate_sync[1]) begin
            ctrl_next[`DTCG_CTRL_EXT_FLAG_ONE] = 1'b1;
        end

        // reads show live state and have no side effect
        if (sfr_rd) begin
            case (sfr_addr)
                `DTCG_ADDR_MODE_SEL: rdata_next = mode_reg;
                `DTCG_ADDR_CTRL_FLAGS: rdata_next = ctrl_reg;
                `DTCG_ADDR_COUNT_LOW_ZERO:
                    rdata_next = count_low_zero_reg;
                `DTCG_ADDR_COUNT_HIGH_ZERO:
                    rdata_next = count_high_zero_reg;
                `DTCG_ADDR_COUNT_LOW_ONE:
                    rdata_next = count_low_one_reg;
                `DTCG_ADDR_COUNT_HIGH_ONE:
                    rdata_next = count_high_one_reg;
                default: rdata_next = `DTCG_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= `DTCG_MODE_RESET;
            ctrl_reg <= `DTCG_CTRL_RESET;
            count_low_zero_reg <= `DTCG_COUNT_RESET;
            count_high_zero_reg <= `DTCG_COUNT_RESET;
            count_low_one_reg <= `DTCG_COUNT_RESET;
            count_high_one_reg <= `DTCG_COUNT_RESET;
            rdata_reg <= `DTCG_UNMAPPED_READ;
            baud_reg <= 1'b0;
        end else if (clk_en) begin
            mode_reg <= mode_next;
            ctrl_reg <= ctrl_next;
            count_low_zero_reg <= count_low_zero_next;
            count_high_zero_reg <= count_high_zero_next;
            count_low_one_reg <= count_low_one_next;
            count_high_one_reg <= count_high_one_next;
            rdata_reg <= rdata_next;
            baud_reg <= baud_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign overflow_flag_zero = ctrl_reg[`DTCG_CTRL_OVF_ZERO];
    assign overflow_flag_one = ctrl_reg[`DTCG_CTRL_OVF_ONE];
    assign ext_irq_flag_zero = ctrl_reg[`DTCG_CTRL_EXT_FLAG_ZERO];
    assign ext_irq_flag_one = ctrl_reg[`DTCG_CTRL_EXT_FLAG_ONE];
    // pulse lasts one clock; consumer must run on the same clock enable
    assign baud_tick_one = baud_reg;

endmodule

`default_nettype wire
